//--- inc/ifv_cfg.svh
// offsets, field positions, reset values and vector addresses of the interrupt flag block
// included by every design file that needs a number and by the bench; the package does not include it
`ifndef IFV_CFG_SVH
`define IFV_CFG_SVH

// register indices; the apb byte address is four times the index
`define IFV_IDX_STAT_A 16'hFE04
`define IFV_IDX_STAT_B 16'hFE05
`define IFV_IDX_STAT_C 16'hFE06
`define IFV_IDX_EVT_STAT 16'hFE10
`define IFV_IDX_EVT_MASK 16'hFE11

// reset values
`define IFV_RST_STAT 8'h00
`define IFV_RST_PEND 17'h00000
`define IFV_RST_MASK 17'h00000

// field positions inside the status registers
`define IFV_A_LSB 2
`define IFV_B_FIRST 7
`define IFV_C_FIRST 15

// source codes of a vector answer
`define IFV_SRC_NONE 5'h00
`define IFV_SRC_SWI 5'h12
`define IFV_SRC_RESET 5'h13

// high byte addresses of the vector pairs
`define IFV_VEC_FLAG1_HI 16'hFFFA
`define IFV_VEC_SWI_HI 16'hFFFC
`define IFV_VEC_RESET_HI 16'hFFFE
`define IFV_VEC_NONE 16'h0000

`endif

//--- inc/ifv_pkg.sv
// types shared by the interrupt flag block, the cpu model and the bench
// assumes ifv_cfg.svh is on the include path
package ifv_pkg;

  // register selected by an apb address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STAT_A,
    SEL_STAT_B,
    SEL_STAT_C,
    SEL_EVT_STAT,
    SEL_EVT_MASK
  } reg_sel_t;

  // answer to a vector fetch
  typedef struct packed {
    logic valid;
    logic [4:0] src;
    logic [15:0] hi_addr;
    logic [15:0] lo_addr;
  } vec_resp_t;

endpackage

//--- logic/irq_flag_vector_map.sv
// interrupt pending flags, apb register file and vector fetch map
// assumes source requests and cpu fetch requests are synchronous to I_REF_CLK
`timescale 1ns/1ps
`include "ifv_cfg.svh"

module irq_flag_vector_map #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // peripheral request pulses, bit n-1 is flag n
  input wire logic [16:0] I_SRC_REQ,
  // cpu vector fetch
  input wire logic I_VEC_REQ,
  input wire logic I_VEC_SWI,
  output ifv_pkg::vec_resp_t O_VEC,
  // interrupt line to the cpu
  output logic O_IRQ
);

  logic [16:0] pend_r;
  logic [16:0] pend_nxt;
  logic [16:0] mask_r;
  logic reset_entry_r;
  logic [4:0] sel_src;
  logic [15:0] sel_hi;
  logic [16:0] sw_clr;
  logic [16:0] fetch_clr;
  logic [31:0] wmask;
  logic setup;
  logic wr_done;
  ifv_pkg::reg_sel_t rd_sel;
  ifv_pkg::reg_sel_t wr_sel;

  // word aligned decode of the five mapped registers
  function automatic ifv_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[17:2];
    decode = ifv_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0 && (addr >> 18) == '0) begin
      if (idx == `IFV_IDX_STAT_A) begin
        decode = ifv_pkg::SEL_STAT_A;
      end else if (idx == `IFV_IDX_STAT_B) begin
        decode = ifv_pkg::SEL_STAT_B;
      end else if (idx == `IFV_IDX_STAT_C) begin
        decode = ifv_pkg::SEL_STAT_C;
      end else if (idx == `IFV_IDX_EVT_STAT) begin
        decode = ifv_pkg::SEL_EVT_STAT;
      end else if (idx == `IFV_IDX_EVT_MASK) begin
        decode = ifv_pkg::SEL_EVT_MASK;
      end
    end
  endfunction

  // read value of each register
  function automatic logic [31:0] rd_value(input ifv_pkg::reg_sel_t s, input logic [16:0] p,
                                           input logic [16:0] m);
    rd_value = 32'h00000000;
    unique case (s)
      ifv_pkg::SEL_STAT_A: begin
        rd_value = {24'h000000, p[5:0], 2'h0};
      end
      ifv_pkg::SEL_STAT_B: begin
        rd_value = {24'h000000, p[13:6]};
      end
      ifv_pkg::SEL_STAT_C: begin
        rd_value = {29'h00000000, p[16:14]};
      end
      ifv_pkg::SEL_EVT_STAT: begin
        rd_value = {15'h0000, p};
      end
      ifv_pkg::SEL_EVT_MASK: begin
        rd_value = {15'h0000, m};
      end
      ifv_pkg::SEL_NONE: begin
        rd_value = 32'h00000000;
      end
    endcase
  endfunction

  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_done = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
  assign rd_sel = decode(I_PADDR);
  assign wr_sel = rd_sel;
  assign wmask = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}}, {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};

  // one wait-free access cycle: the answer is prepared during setup
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end else begin
      O_PREADY <= setup;
      O_PSLVERR <= setup & (rd_sel == ifv_pkg::SEL_NONE);
      O_PRDATA <= (setup & ~I_PWRITE) ? rd_value(rd_sel, pend_r, mask_r) : 32'h00000000;
    end
  end

  // mask register
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      mask_r <= `IFV_RST_MASK;
    end else if (wr_done && wr_sel == ifv_pkg::SEL_EVT_MASK) begin
      mask_r <= (mask_r & ~wmask[16:0]) | (I_PWDATA[16:0] & wmask[16:0]);
    end
  end

  // clears from software (write one) and from a served fetch
  assign sw_clr = (wr_done && wr_sel == ifv_pkg::SEL_EVT_STAT) ?
                  (I_PWDATA[16:0] & wmask[16:0]) : 17'h00000;

  vector_select u_vector_select (
    .i_pend(pend_r & mask_r),
    .i_swi(I_VEC_SWI),
    .i_reset_entry(reset_entry_r),
    .o_src(sel_src),
    .o_hi(sel_hi)
  );

  always_comb begin
    fetch_clr = 17'h00000;
    if (I_VEC_REQ && sel_src != `IFV_SRC_NONE && sel_src < `IFV_SRC_SWI) begin
      fetch_clr[sel_src - 5'h01] = 1'b1;
    end
  end

  // a request in the same cycle as a clear keeps its flag
  assign pend_nxt = (pend_r & ~(sw_clr | fetch_clr)) | I_SRC_REQ;

  // pending flags, cleared by reset
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pend_r <= `IFV_RST_PEND;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // reset entry stands until its vector has been fetched
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      reset_entry_r <= 1'b1;
    end else if (I_VEC_REQ && sel_src == `IFV_SRC_RESET) begin
      reset_entry_r <= 1'b0;
    end
  end

  // vector answer, one cycle after the fetch request
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_VEC <= '0;
    end else begin
      O_VEC.valid <= I_VEC_REQ;
      if (I_VEC_REQ) begin
        O_VEC.src <= sel_src;
        O_VEC.hi_addr <= sel_hi;
        O_VEC.lo_addr <= (sel_src == `IFV_SRC_NONE) ? `IFV_VEC_NONE : {sel_hi[15:1], 1'b1};
      end
    end
  end

  // level interrupt while an unmasked flag is pending
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(pend_nxt & mask_r);
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_rd_setup(ifv_pkg::reg_sel_t s);
    I_PSEL && !I_PENABLE && !I_PWRITE && rd_sel == s;
  endsequence

  sequence s_fetch(logic [4:0] n);
    I_VEC_REQ && sel_src == n;
  endsequence

  a_stat_a_read: assert property (
    s_rd_setup(ifv_pkg::SEL_STAT_A) |=>
      O_PREADY && O_PRDATA[1:0] == 2'h0 && O_PRDATA[7:2] == $past(pend_r[5:0])
      && O_PRDATA[31:8] == 24'h000000)
    else $error("first status register read wrong");

  a_stat_b_read: assert property (
    s_rd_setup(ifv_pkg::SEL_STAT_B) |=>
      O_PREADY && O_PRDATA == {24'h000000, $past(pend_r[13:6])})
    else $error("second status register read wrong");

  a_stat_c_read: assert property (
    s_rd_setup(ifv_pkg::SEL_STAT_C) |=>
      O_PREADY && O_PRDATA[2:0] == $past(pend_r[16:14]) && O_PRDATA[31:3] == 29'h00000000)
    else $error("third status register read wrong");

  a_rtc_vector: assert property (
    s_fetch(5'h11) |=> O_VEC.valid && O_VEC.hi_addr == 16'hFFDA && O_VEC.lo_addr == 16'hFFDB)
    else $error("clock tick vector address wrong");

  a_prio_order: assert property (
    I_VEC_REQ && !reset_entry_r && !I_VEC_SWI && (pend_r[0] & mask_r[0]) |=>
      O_VEC.src == 5'h01 && O_VEC.hi_addr == 16'hFFFA)
    else $error("lower entry beat external pin");

  a_prio_lowest: assert property (
    I_VEC_REQ && !reset_entry_r && !I_VEC_SWI && (pend_r & mask_r) == 17'h10000 |=>
      O_VEC.src == 5'h11)
    else $error("clock tick alone not served");

  a_conv_keypad: assert property (
    O_VEC.valid |->
      (O_VEC.src == 5'h10 -> O_VEC.hi_addr == 16'hFFDC && O_VEC.lo_addr == 16'hFFDD)
      && (O_VEC.src == 5'h0F -> O_VEC.hi_addr == 16'hFFDE && O_VEC.lo_addr == 16'hFFDF))
    else $error("converter or keypad vector wrong");

  a_serial_vec: assert property (
    O_VEC.valid |->
      (O_VEC.src == 5'h0E -> O_VEC.hi_addr == 16'hFFE0)
      && (O_VEC.src == 5'h0D -> O_VEC.hi_addr == 16'hFFE2)
      && (O_VEC.src == 5'h0C -> O_VEC.hi_addr == 16'hFFE4))
    else $error("serial vector wrong");

  a_spi_vec: assert property (
    O_VEC.valid |->
      (O_VEC.src == 5'h0B -> O_VEC.hi_addr == 16'hFFE6)
      && (O_VEC.src == 5'h0A -> O_VEC.hi_addr == 16'hFFE8))
    else $error("spi vector wrong");

  a_timer_b_vec: assert property (
    O_VEC.valid |->
      (O_VEC.src == 5'h09 -> O_VEC.hi_addr == 16'hFFEA)
      && (O_VEC.src == 5'h08 -> O_VEC.hi_addr == 16'hFFEC)
      && (O_VEC.src == 5'h07 -> O_VEC.hi_addr == 16'hFFEE))
    else $error("second timer vector wrong");

  a_timer_a_vec: assert property (
    O_VEC.valid |->
      (O_VEC.src == 5'h06 -> O_VEC.hi_addr == 16'hFFF0)
      && (O_VEC.src == 5'h05 -> O_VEC.hi_addr == 16'hFFF2)
      && (O_VEC.src == 5'h04 -> O_VEC.hi_addr == 16'hFFF4))
    else $error("first timer vector wrong");

  a_misc_vec: assert property (
    O_VEC.valid |->
      (O_VEC.src == 5'h03 -> O_VEC.hi_addr == 16'hFFF6)
      && (O_VEC.src == 5'h02 -> O_VEC.hi_addr == 16'hFFF8)
      && (O_VEC.src == 5'h01 -> O_VEC.hi_addr == 16'hFFFA))
    else $error("synthesizer, low voltage or pin vector wrong");

  a_reset_first: assert property (
    I_VEC_REQ && reset_entry_r |=>
      O_VEC.src == 5'h13 && O_VEC.hi_addr == 16'hFFFE && O_VEC.lo_addr == 16'hFFFF
      ##0 !reset_entry_r)
    else $error("reset entry not served first");

  a_trap_next: assert property (
    I_VEC_REQ && !reset_entry_r && I_VEC_SWI |=>
      O_VEC.src == 5'h12 && O_VEC.hi_addr == 16'hFFFC && O_VEC.lo_addr == 16'hFFFD)
    else $error("trap did not win over flags");

  a_set_wins: assert property (
    I_SRC_REQ != 17'h00000 |=> (pend_r & $past(I_SRC_REQ)) == $past(I_SRC_REQ))
    else $error("request lost against a clear");

  a_irq_level: assert property (
    ((pend_r & mask_r) != 17'h00000) [*2] |-> O_IRQ)
    else $error("interrupt line low with unmasked flag");

  a_apb_answer: assert property (
    I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
    else $error("apb answer not in first access cycle");

  a_unmapped_err: assert property (
    I_PSEL && !I_PENABLE && rd_sel == ifv_pkg::SEL_NONE |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access not flagged");

endmodule

//--- logic/vector_select.sv
// fixed priority vector selector: picks the served entry and its high byte address
// assumes pending flags are already gated by the mask; combinational only
`timescale 1ns/1ps
`include "ifv_cfg.svh"

module vector_select (
  // candidates
  input wire logic [16:0] i_pend,
  input wire logic i_swi,
  input wire logic i_reset_entry,
  // choice
  output logic [4:0] o_src,
  output logic [15:0] o_hi
);

  // flag n sits two bytes below flag n-1, flag one just under the trap pair
  function automatic logic [15:0] flag_hi(input logic [4:0] n);
    flag_hi = 16'(`IFV_VEC_SWI_HI - {10'h000, n, 1'b0});
  endfunction

  always_comb begin
    o_src = `IFV_SRC_NONE;
    // lowest address first, so a higher entry overrides it
    for (int i = 16; i >= 0; i--) begin
      if (i_pend[i]) begin
        o_src = 5'(i + 1);
      end
    end
    if (i_swi) begin
      o_src = `IFV_SRC_SWI;
    end
    if (i_reset_entry) begin
      o_src = `IFV_SRC_RESET;
    end
    if (o_src == `IFV_SRC_RESET) begin
      o_hi = `IFV_VEC_RESET_HI;
    end else if (o_src == `IFV_SRC_SWI) begin
      o_hi = `IFV_VEC_SWI_HI;
    end else if (o_src == `IFV_SRC_NONE) begin
      o_hi = `IFV_VEC_NONE;
    end else begin
      o_hi = flag_hi(o_src);
    end
  end

endmodule

//--- testbench/cpu_vec_model.sv
// cpu side of the vector fetch: pulses a fetch request and takes the answer
// assumes the answer comes as a one-cycle valid pulse after the request edge
`timescale 1ns/1ps

module cpu_vec_model (
  // clock
  input wire logic i_clk,
  // fetch answer
  input wire ifv_pkg::vec_resp_t i_vec,
  // fetch request
  output logic o_req,
  output logic o_swi
);
  initial begin
    o_req = 1'b0;
    o_swi = 1'b0;
  end

  // gap idles the cpu before the request, for slow fetches
  task automatic fetch(input logic software_trap, input int gap, output ifv_pkg::vec_resp_t resp);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_swi <= software_trap;
    @(posedge i_clk);
    o_req <= 1'b0;
    o_swi <= 1'b0;
    // the answer is taken at the edge where valid is seen high
    do begin
      @(posedge i_clk);
    end while (i_vec.valid !== 1'b1);
    resp = i_vec;
  endtask
endmodule

//--- testbench/test_interrupt_flag_and_vector_map.sv
// self-checking bench for the interrupt flag and vector map block
// assumes the package, ifv_cfg.svh and the cpu model are compiled first
`timescale 1ns/1ps
`include "ifv_cfg.svh"
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("wrong value at %0t got %h expected %h", $time, got, exp); \
  end \
end

module test_interrupt_flag_and_vector_map;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, vreq, vswi;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [16:0] src_req;
  ifv_pkg::vec_resp_t vec;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  irq_flag_vector_map #(.ADDR_W(18)) dut (
    .I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SRC_REQ(src_req), .I_VEC_REQ(vreq), .I_VEC_SWI(vswi), .O_VEC(vec), .O_IRQ(irq)
  );

  cpu_vec_model cpu (.i_clk(clk), .i_vec(vec), .o_req(vreq), .o_swi(vswi));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    `CHK(d, exp)
    `CHK(e, 1'b0)
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
    `CHK(e, 1'b0)
  endtask

  task automatic pulse(input logic [16:0] v);
    @(posedge clk);
    src_req <= v;
    @(posedge clk);
    src_req <= 17'h00000;
  endtask

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, exp)
  endtask

  task automatic vchk(input logic software_trap, input logic [4:0] src, input logic [15:0] hi);
    ifv_pkg::vec_resp_t r;
    cpu.fetch(software_trap, int'(src[0]), r);
    `CHK(r, {1'b1, src, hi, (hi == 16'h0000) ? 16'h0000 : hi + 16'h0001})
  endtask

  initial begin
    logic [31:0] d;
    logic e;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    src_req = 17'h00000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`IFV_IDX_STAT_A, 32'h0);
    rd(`IFV_IDX_STAT_B, 32'h0);
    rd(`IFV_IDX_STAT_C, 32'h0);
    vchk(1'b1, `IFV_SRC_RESET, `IFV_VEC_RESET_HI);
    $display("test reset done");
    pulse(17'h1FFFF);
    wr(`IFV_IDX_STAT_A, 32'h0);
    rd(`IFV_IDX_STAT_A, 32'hFC);
    rd(`IFV_IDX_STAT_B, 32'hFF);
    rd(`IFV_IDX_STAT_C, 32'h07);
    wr(`IFV_IDX_EVT_MASK, 32'h1FFFF);
    irqchk(1'b1);
    vchk(1'b1, `IFV_SRC_SWI, `IFV_VEC_SWI_HI);
    for (int n = 1; n <= 17; n++) begin
      vchk(1'b0, 5'(n), 16'hFFFC - 16'(2 * n));
    end
    irqchk(1'b0);
    vchk(1'b0, `IFV_SRC_NONE, `IFV_VEC_NONE);
    $display("test vector map done");
    wr(`IFV_IDX_EVT_MASK, 32'h0);
    pulse(17'h00010);
    irqchk(1'b0);
    rd(`IFV_IDX_STAT_A, 32'h40);
    rd(`IFV_IDX_EVT_STAT, 32'h10);
    wr(`IFV_IDX_EVT_MASK, 32'h10);
    irqchk(1'b1);
    wr(`IFV_IDX_EVT_STAT, 32'h10);
    irqchk(1'b0);
    rd(`IFV_IDX_STAT_A, 32'h0);
    pulse(17'h10000);
    rd(`IFV_IDX_STAT_C, 32'h04);
    apb(1'b0, 16'hFE07, 32'h0, d, e);
    `CHK(d, 32'h0)
    `CHK(e, 1'b1)
    $display("test interrupt line done");
    // reset in mid-run clears every flag and arms the reset entry again
    pulse(17'h1FFFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`IFV_IDX_STAT_A, 32'h0);
    rd(`IFV_IDX_STAT_B, 32'h0);
    rd(`IFV_IDX_STAT_C, 32'h0);
    vchk(1'b0, `IFV_SRC_RESET, `IFV_VEC_RESET_HI);
    $display("test second reset done");
    final_report();
  end
endmodule
